// >>> hw/mafps_defs.svh
// Register offsets, field positions and reset values of the
// address filter, pause and statistics register block.
// Assumes byte addresses on a 32-bit Avalon-MM slave port.
`ifndef MAFPS_DEFS_SVH
`define MAFPS_DEFS_SVH

// Byte offsets of the registers
`define MAFPS_OFS_PAUSE    8'h00
`define MAFPS_OFS_HASH_LO  8'h04
`define MAFPS_OFS_HASH_HI  8'h08
`define MAFPS_OFS_SLOT     8'h0C
`define MAFPS_SLOT_STRIDE  8'h08
`define MAFPS_OFS_TYPE     8'h2C
`define MAFPS_OFS_PHYCTL   8'h30
`define MAFPS_OFS_PFCNT    8'h34
`define MAFPS_OFS_STATUS   8'h38
`define MAFPS_OFS_NETCTL   8'h3C
`define MAFPS_OFS_NETCFG   8'h40

// Field positions
`define MAFPS_BIT_RMII     0
`define MAFPS_BIT_TRANSCEIVER_CLOCK_GATE    1
`define MAFPS_BIT_RXEN     2
`define MAFPS_BIT_STATWE   7
`define MAFPS_BIT_BIGFRM   8
`define MAFPS_BIT_PEXP     13

// Reset values
`define MAFPS_RST_WORD     32'h0000_0000
`define MAFPS_RST_HALF     16'h0000
`define MAFPS_RST_BIT      1'b0

// Frame length limits in bytes
`define MAFPS_LEN_MIN      16'h0040
`define MAFPS_LEN_MAX      16'h05EE
`define MAFPS_LEN_MAX_BIG  16'h0600

`endif

// >>> hw/mafps_pkg.sv
// Types shared by the address filter, pause and statistics block.
// Assumes the constants of mafps_defs.svh alongside.
package mafps_pkg;

  // Bus handshake phases
  typedef enum logic {
    BUS_IDLE,
    BUS_DONE
  } mafps_bus_state_t;

  typedef logic [31:0] mafps_word_t;
  typedef logic [15:0] mafps_half_t;

endpackage

// >>> hw/mafps_regs.sv
// Pause countdown, hash filter, destination match slots, frame type
// compare, PHY interface control and the good pause frame counter.
// Assumes an Avalon-MM master on clk and receive events on clk.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "mafps_defs.svh"

module mafps_regs #(
  parameter int SLOTS  = 4,
  parameter int STAT_W = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Pause timing from the MAC core
  input  wire logic              pauseQuantumTick,
  input  wire logic              pauseLoad,
  input  wire logic [15:0]       pauseLoadValue,
  // Received frame summary
  input  wire logic              rxFrameDone,
  input  wire logic              rxFrameIsPause,
  input  wire logic [15:0]       rxFrameLength,
  input  wire logic              rxFcsError,
  input  wire logic              rxAlignError,
  input  wire logic              rxSymbolError,
  // Received header fields
  input  wire logic [47:0]       rxDestAddr,
  input  wire logic [5:0]        rxHashIndex,
  input  wire logic [15:0]       rxTypeField,
  // Filter results
  output logic      [SLOTS-1:0]  slotMatch,
  output logic                   hashHit,
  output logic                   typeMatch,
  // Status towards the MAC core
  output logic                   pauseActive,
  output logic                   pauseExpiredFlag,
  // PHY side control
  output logic                   rmiiSelect,
  output logic                   transceiverClockGate
);

  // Bus handshake state
  mafps_pkg::mafps_bus_state_t busState_r;
  mafps_pkg::mafps_bus_state_t busState_nxt;
  logic [31:0]                 readdata_r;
  logic [31:0]                 readdata_nxt;
  logic                        busReq;
  logic                        rdCapture;
  logic                        wrAccept;

  // Software visible storage
  logic [15:0]                 pauseCount_r;
  logic [15:0]                 pauseCount_nxt;
  logic                        pauseExpired_r;
  logic                        pauseExpired_nxt;
  logic [63:0]                 hash_r;
  logic [63:0]                 hash_nxt;
  logic [31:0]                 slotLow_r [SLOTS];
  logic [31:0]                 slotLow_nxt [SLOTS];
  logic [15:0]                 slotHigh_r [SLOTS];
  logic [15:0]                 slotHigh_nxt [SLOTS];
  logic [15:0]                 frameType_r;
  logic [15:0]                 frameType_nxt;
  logic [1:0]                  phyCtl_r;
  logic [1:0]                  phyCtl_nxt;
  logic                        rxEnable_r;
  logic                        rxEnable_nxt;
  logic                        statWriteEn_r;
  logic                        statWriteEn_nxt;
  logic                        bigFrames_r;
  logic                        bigFrames_nxt;
  logic [STAT_W-1:0]           pauseFrames_r;
  logic [STAT_W-1:0]           pauseFrames_nxt;

  // Filter result registers
  logic [SLOTS-1:0]            slotMatch_r;
  logic [SLOTS-1:0]            slotMatch_nxt;
  logic                        hashHit_r;
  logic                        hashHit_nxt;
  logic                        typeMatch_r;
  logic                        typeMatch_nxt;

  // Frame qualification
  logic [15:0]                 lenLimit;
  logic                        goodPause;

  // True when addr selects the low or high word of slot idx
  // Shared by the read mux and the write decode
  function automatic logic slotHit(
    input logic [7:0] addr,
    input int         idx,
    input logic       high
  );
    logic [7:0] base;
    base = `MAFPS_OFS_SLOT + 8'(idx) * `MAFPS_SLOT_STRIDE;
    // High word sits one word above the low word
    if (high) begin
      base = base + 8'h04;
    end
    return addr == base;
  endfunction

  // Handshake: one wait state, then waitrequest low for one cycle
  // Read side effects fire on the first cycle only, once per read
  // Writes land on the edge that ends the cycle with waitrequest low
  assign busReq      = read | write;
  assign rdCapture   = read & (busState_r == mafps_pkg::BUS_IDLE);
  assign wrAccept    = write & (busState_r == mafps_pkg::BUS_DONE);
  assign waitrequest = busReq & (busState_r != mafps_pkg::BUS_DONE);
  assign readdata    = readdata_r;

  // Next bus state and read data capture
  always_comb begin
    busState_nxt = busState_r;
    readdata_nxt = readdata_r;
    case (busState_r)
      mafps_pkg::BUS_IDLE: begin
        if (busReq) begin
          busState_nxt = mafps_pkg::BUS_DONE;
        end
        // Read data latched while waitrequest is high
        if (read) begin
          // Reserved and unmapped bits read as zero
          readdata_nxt = `MAFPS_RST_WORD;
          case (address)
            `MAFPS_OFS_PAUSE:   readdata_nxt[15:0] = pauseCount_r;
            `MAFPS_OFS_HASH_LO: readdata_nxt = hash_r[31:0];
            `MAFPS_OFS_HASH_HI: readdata_nxt = hash_r[63:32];
            `MAFPS_OFS_TYPE:    readdata_nxt[15:0] = frameType_r;
            `MAFPS_OFS_PHYCTL:  readdata_nxt[1:0] = phyCtl_r;
            `MAFPS_OFS_PFCNT:   readdata_nxt[STAT_W-1:0] = pauseFrames_r;
            `MAFPS_OFS_STATUS:  readdata_nxt[`MAFPS_BIT_PEXP] = pauseExpired_r;
            `MAFPS_OFS_NETCTL: begin
              readdata_nxt[`MAFPS_BIT_RXEN]   = rxEnable_r;
              readdata_nxt[`MAFPS_BIT_STATWE] = statWriteEn_r;
            end
            `MAFPS_OFS_NETCFG:  readdata_nxt[`MAFPS_BIT_BIGFRM] = bigFrames_r;
            default: begin
              // Slot words decoded by the shared address function
              for (int i = 0; i < SLOTS; i++) begin
                if (slotHit(address, i, 1'b0)) begin
                  readdata_nxt = slotLow_r[i];
                end
                if (slotHit(address, i, 1'b1)) begin
                  readdata_nxt[15:0] = slotHigh_r[i];
                end
              end
            end
          endcase
        end
      end
      mafps_pkg::BUS_DONE: begin
        // Second cycle: waitrequest low, back to idle
        busState_nxt = mafps_pkg::BUS_IDLE;
      end
      default: begin
        busState_nxt = mafps_pkg::BUS_IDLE;
      end
    endcase
  end

  // Bus state registers
  // readdata_r holds until the next read is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busState_r <= mafps_pkg::BUS_IDLE;
      readdata_r <= `MAFPS_RST_WORD;
    end else begin
      busState_r <= busState_nxt;
      readdata_r <= readdata_nxt;
    end
  end

  // Next values of plain read-write configuration
  always_comb begin
    hash_nxt        = hash_r;
    frameType_nxt   = frameType_r;
    phyCtl_nxt      = phyCtl_r;
    rxEnable_nxt    = rxEnable_r;
    statWriteEn_nxt = statWriteEn_r;
    bigFrames_nxt   = bigFrames_r;
    for (int i = 0; i < SLOTS; i++) begin
      slotLow_nxt[i]  = slotLow_r[i];
      slotHigh_nxt[i] = slotHigh_r[i];
    end
    // Accepted writes only, never during the wait state
    if (wrAccept) begin
      // Counter and pause writes are handled with their own state
      case (address)
        `MAFPS_OFS_HASH_LO: hash_nxt[31:0]  = writedata;
        `MAFPS_OFS_HASH_HI: hash_nxt[63:32] = writedata;
        `MAFPS_OFS_TYPE:    frameType_nxt = writedata[15:0];
        `MAFPS_OFS_PHYCTL:  phyCtl_nxt = writedata[1:0];
        `MAFPS_OFS_NETCTL: begin
          rxEnable_nxt    = writedata[`MAFPS_BIT_RXEN];
          statWriteEn_nxt = writedata[`MAFPS_BIT_STATWE];
        end
        `MAFPS_OFS_NETCFG:  bigFrames_nxt = writedata[`MAFPS_BIT_BIGFRM];
        default: begin
          for (int i = 0; i < SLOTS; i++) begin
            if (slotHit(address, i, 1'b0)) begin
              slotLow_nxt[i] = writedata;
            end
            if (slotHit(address, i, 1'b1)) begin
              slotHigh_nxt[i] = writedata[15:0];
            end
          end
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Cleared storage; software programs filters after reset
      hash_r        <= {`MAFPS_RST_WORD, `MAFPS_RST_WORD};
      frameType_r   <= `MAFPS_RST_HALF;
      phyCtl_r      <= {`MAFPS_RST_BIT, `MAFPS_RST_BIT};
      rxEnable_r    <= `MAFPS_RST_BIT;
      statWriteEn_r <= `MAFPS_RST_BIT;
      bigFrames_r   <= `MAFPS_RST_BIT;
      for (int i = 0; i < SLOTS; i++) begin
        slotLow_r[i]  <= `MAFPS_RST_WORD;
        slotHigh_r[i] <= `MAFPS_RST_HALF;
      end
    end else begin
      hash_r        <= hash_nxt;
      frameType_r   <= frameType_nxt;
      phyCtl_r      <= phyCtl_nxt;
      rxEnable_r    <= rxEnable_nxt;
      statWriteEn_r <= statWriteEn_nxt;
      bigFrames_r   <= bigFrames_nxt;
      for (int i = 0; i < SLOTS; i++) begin
        slotLow_r[i]  <= slotLow_nxt[i];
        slotHigh_r[i] <= slotHigh_nxt[i];
      end
    end
  end

  // Pause countdown and its expired flag
  always_comb begin
    pauseCount_nxt   = pauseCount_r;
    pauseExpired_nxt = pauseExpired_r;
    // Read clear first so a same-cycle expiry still sets
    if (rdCapture && address == `MAFPS_OFS_STATUS) begin
      pauseExpired_nxt = 1'b0;
    end
    // Software write wins over a load, a load over a tick
    if (wrAccept && address == `MAFPS_OFS_PAUSE) begin
      pauseCount_nxt = writedata[15:0];
    end else if (pauseLoad) begin
      pauseCount_nxt = pauseLoadValue;
    end else if (pauseQuantumTick && pauseCount_r != `MAFPS_RST_HALF) begin
      // Count never wraps below zero
      pauseCount_nxt = pauseCount_r - 16'h0001;
      // Flag only on a real one to zero step, not on writing zero
      if (pauseCount_r == 16'h0001) begin
        pauseExpired_nxt = 1'b1;
      end
    end
  end

  // Pause registers
  // Count and flag reset idle: no pause pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pauseCount_r   <= `MAFPS_RST_HALF;
      pauseExpired_r <= `MAFPS_RST_BIT;
    end else begin
      pauseCount_r   <= pauseCount_nxt;
      pauseExpired_r <= pauseExpired_nxt;
    end
  end

  // Good pause frame qualification
  // Length limits are inclusive; any receive error disqualifies
  // Receive enable gates counting only, not the filters
  assign lenLimit  = bigFrames_r ? `MAFPS_LEN_MAX_BIG : `MAFPS_LEN_MAX;
  assign goodPause = rxFrameDone & rxFrameIsPause & rxEnable_r
                   & (rxFrameLength >= `MAFPS_LEN_MIN)
                   & (rxFrameLength <= lenLimit)
                   & ~(rxFcsError | rxAlignError | rxSymbolError);

  // Pause frame counter: clear on read, saturate, gated writes
  always_comb begin
    pauseFrames_nxt = pauseFrames_r;
    if (rdCapture && address == `MAFPS_OFS_PFCNT) begin
      pauseFrames_nxt = '0;
    end
    // Event in the clearing cycle counts from zero; sticks at all ones
    if (goodPause && pauseFrames_nxt != {STAT_W{1'b1}}) begin
      pauseFrames_nxt = pauseFrames_nxt + STAT_W'(1);
    end
    // Gated software write beats a same-cycle event
    if (wrAccept && address == `MAFPS_OFS_PFCNT && statWriteEn_r) begin
      pauseFrames_nxt = writedata[STAT_W-1:0];
    end
  end

  // Counter register
  // Width follows STAT_W; saturation value tracks it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pauseFrames_r <= '0;
    end else begin
      pauseFrames_r <= pauseFrames_nxt;
    end
  end

  // Destination slot compare, first byte in rxDestAddr[7:0]
  // Results lag the header inputs by one clock
  // Multicast bit is rxDestAddr[0], the first byte's first bit
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : gSlot
      assign slotMatch_nxt[g] = rxDestAddr == {slotHigh_r[g], slotLow_r[g]};
    end
  endgenerate

  // Hash and type compare
  always_comb begin
    // Index picks one of the 64 hash bits
    hashHit_nxt   = hash_r[rxHashIndex];
    typeMatch_nxt = rxTypeField == frameType_r;
  end

  // Filter result registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slotMatch_r <= '0;
      hashHit_r   <= `MAFPS_RST_BIT;
      typeMatch_r <= `MAFPS_RST_BIT;
    end else begin
      slotMatch_r <= slotMatch_nxt;
      hashHit_r   <= hashHit_nxt;
      typeMatch_r <= typeMatch_nxt;
    end
  end

  // Outputs
  assign slotMatch            = slotMatch_r;
  assign hashHit              = hashHit_r;
  assign typeMatch            = typeMatch_r;
  // Pause stays asserted while the countdown is nonzero
  assign pauseActive          = pauseCount_r != `MAFPS_RST_HALF;
  assign pauseExpiredFlag     = pauseExpired_r;
  // Interface select and clock enable go straight to the PHY side
  assign rmiiSelect           = phyCtl_r[`MAFPS_BIT_RMII];
  assign transceiverClockGate = phyCtl_r[`MAFPS_BIT_TRANSCEIVER_CLOCK_GATE];

endmodule

// >>> dv/mafps_sva.sv
// Pin-level assertions for the address filter, pause and statistics block.
// Assumes binding into mafps_regs; one clock, rst_n async active low.
`timescale 1ns/1ps
`include "mafps_defs.svh"
module mafps_sva #(
  parameter int SLOTS = 4
) (
  // Clock, reset and inputs
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic [7:0]       address,
  input wire logic             read,
  input wire logic             write,
  input wire logic [31:0]      writedata,
  input wire logic             pauseQuantumTick,
  input wire logic             pauseLoad,
  input wire logic [47:0]      rxDestAddr,
  input wire logic [15:0]      rxTypeField,
  // Outputs
  input wire logic             waitrequest,
  input wire logic [SLOTS-1:0] slotMatch,
  input wire logic             typeMatch,
  input wire logic             pauseActive,
  input wire logic             pauseExpiredFlag,
  input wire logic             rmiiSelect,
  input wire logic             transceiverClockGate
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Completed write to the interface control register
  logic ctlWr;
  assign ctlWr = write && !waitrequest && address == `MAFPS_OFS_PHYCTL;

  // Bus timing, control bits, pause countdown and filter outputs
  chk_one_wait: assert property (waitrequest |=> !waitrequest)
    else $error("request waited more than one cycle");
  chk_rmii_bit: assert property (ctlWr |=> rmiiSelect == $past(writedata[0]))
    else $error("interface select does not follow bit 0");
  chk_clock_gate: assert property (ctlWr |=> transceiverClockGate == $past(writedata[1]))
    else $error("clock enable does not follow bit 1");
  chk_pause_hold: assert property (pauseActive && !pauseQuantumTick && !pauseLoad && !write |=> pauseActive)
    else $error("pause count ended without a tick");
  chk_expire_set: assert property ($fell(pauseActive) && !$past(write) && !$past(pauseLoad) |-> pauseExpiredFlag)
    else $error("expired flag not set at zero");
  chk_expire_clear: assert property (read && waitrequest && address == `MAFPS_OFS_STATUS
    && !pauseQuantumTick |=> !pauseExpiredFlag)
    else $error("expired flag survived a status read");
  chk_type_steady: assert property ($past(rst_n) && $stable(rxTypeField) && !$past(write) |=> $stable(typeMatch))
    else $error("type match changed without cause");
  chk_slot_cause: assert property ($changed(slotMatch) |-> !$past(rst_n) || !$past(rst_n, 2) || $past(write, 2)
    || $past(rxDestAddr) != $past(rxDestAddr, 2))
    else $error("slot match changed without cause");
endmodule

// >>> dv/mafps_phy_model.sv
// Behavioural transceiver side feeding received frame summaries in.
// Assumes the bench calls sendFrame just after a clk edge.
`timescale 1ns/1ps
module mafps_phy_model (
  // Clock and transceiver clock enable
  input  wire logic   clk,
  input  wire logic   clockGate,
  // Frame summary towards the block
  output logic        rxFrameDone,
  output logic        rxFrameIsPause,
  output logic [15:0] rxFrameLength,
  output logic [2:0]  rxErrors
);
  // Quiet lines until the first frame
  initial begin
    rxFrameDone = 1'b0;
    rxFrameIsPause = 1'b0;
    rxFrameLength = 16'h0000;
    rxErrors = 3'h0;
  end

  // One summary; a stopped transceiver clock delivers nothing
  task automatic sendFrame(input logic [15:0] len, input logic [2:0] err, input logic isPause);
    @(posedge clk);
    rxFrameDone <= clockGate === 1'b1;
    rxFrameIsPause <= isPause;
    rxFrameLength <= len;
    rxErrors <= err;
    @(posedge clk);
    rxFrameDone <= 1'b0;
    rxFrameIsPause <= !isPause;
    rxFrameLength <= ~len;
    rxErrors <= ~err;
    @(posedge clk);
  endtask
endmodule

// >>> dv/mac_addr_filter_pause_stats_test.sv
// Self-checking bench for the address filter, pause and statistics block.
// Assumes the design, partner model and checker are compiled before it.
`timescale 1ns/1ps
`include "mafps_defs.svh"
module mac_addr_filter_pause_stats_test;
  // Stimulus, observed pins and bookkeeping
  logic        clk, rst_n, read, write, waitrequest, pauseQuantumTick, pauseLoad;
  logic        hashHit, typeMatch, pauseActive, pauseExpiredFlag, rmiiSelect, transceiverClockGate;
  logic        rxFrameDone, rxFrameIsPause;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, m;
  logic [15:0] pauseLoadValue, rxTypeField, rxFrameLength;
  logic [47:0] rxDestAddr;
  logic [5:0]  rxHashIndex;
  logic [3:0]  slotMatch;
  logic [2:0]  rxErrors;
  int          nMismatch, nChecks, i, j, n;
  // Frame table; entry 7 is not a pause frame
  logic [15:0] lens [10] = '{16'h003F, 16'h0040, 16'h05EE, 16'h05EF, 16'h0040,
                             16'h0040, 16'h0040, 16'h0064, 16'h0600, 16'h0601};
  logic [2:0]  errs [10] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h4, 3'h0, 3'h0, 3'h0};
  logic [5:0]  hIdx [4]  = '{6'h03, 6'h25, 6'h24, 6'h02};

  // Design and transceiver model
  mafps_regs dut_u (.clk, .rst_n, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .pauseQuantumTick, .pauseLoad, .pauseLoadValue, .rxFrameDone, .rxFrameIsPause, .rxFrameLength,
    .rxFcsError(rxErrors[0]), .rxAlignError(rxErrors[1]), .rxSymbolError(rxErrors[2]), .rxDestAddr,
    .rxHashIndex, .rxTypeField, .slotMatch, .hashHit, .typeMatch, .pauseActive, .pauseExpiredFlag,
    .rmiiSelect, .transceiverClockGate);
  mafps_phy_model phyU (.clk, .clockGate(transceiverClockGate), .rxFrameDone, .rxFrameIsPause,
    .rxFrameLength, .rxErrors);

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic printVerdict();
    if (nMismatch == 0 && nChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error at %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // One bus transfer, held until waitrequest is seen low
  task automatic busXfer(input logic isWrite, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !isWrite;
    write <= isWrite;
    do begin
      @(posedge clk);
      t++;
    end while (waitrequest !== 1'b0 && t < 16);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    #1;
    if (t >= 16) begin
      nMismatch++;
      printVerdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    busXfer(1'b1, a, d, q);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    busXfer(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask

  task automatic frame(input int k);
    phyU.sendFrame(lens[k], errs[k], k != 7);
  endtask

  initial begin
    nMismatch = 0;
    nChecks = 0;
    rst_n = 1'b0;
    {read, write, pauseQuantumTick, pauseLoad} = 4'h0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    pauseLoadValue = 16'h0000;
    rxDestAddr = 48'h0000_0000_0000;
    rxHashIndex = 6'h00;
    rxTypeField = 16'h0000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values; the unmapped place ignores writes
    wr(8'h44, 32'hFFFF_FFFF);
    for (i = 0; i <= 8'h44; i += 4) begin
      rdChk(i[7:0], 32'h0000_0000);
    end
    // Read back each register from offset 0x00 to 0x30 through its field mask
    for (i = 0; i <= 8'h30; i += 4) begin
      m = (i == 0 || i == 8'h2C || (i >= 8'h10 && i[2:0] == 3'h0)) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
      m = (i == 8'h30) ? 32'h0000_0003 : m;
      wr(i[7:0], 32'hA5C3_5A3C ^ i);
      rdChk(i[7:0], (32'hA5C3_5A3C ^ i) & m);
    end
    // Every interface select and clock enable setting
    for (i = 0; i < 4; i++) begin
      wr(`MAFPS_OFS_PHYCTL, 32'(i));
      chk({transceiverClockGate, rmiiSelect}, 32'(i));
    end
    // Each slot matches its own 48-bit address only
    for (i = 0; i < 4; i++) begin
      wr(8'(`MAFPS_OFS_SLOT + 8 * i), 32'h1357_9BD1 + i);
      wr(8'(`MAFPS_OFS_SLOT + 8 * i + 4), 32'hFFFF_2460 + i);
      @(posedge clk);
      rxDestAddr <= {16'h2460 + 16'(i), 32'h1357_9BD1 + i};
      settle(2);
      chk(slotMatch, 32'h1 << i);
    end
    // Hash bits in both halves and the frame type value
    wr(`MAFPS_OFS_HASH_LO, 32'h0000_0008);
    wr(`MAFPS_OFS_HASH_HI, 32'h0000_0020);
    wr(`MAFPS_OFS_TYPE, 32'h0000_8808);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      rxHashIndex <= hIdx[i];
      rxTypeField <= 16'h8807 + 16'(i);
      settle(2);
      chk(hashHit, i < 2);
      chk(typeMatch, i == 1);
    end
    // Loaded count runs down on ticks and flags expiry once
    @(posedge clk);
    pauseLoad <= 1'b1;
    pauseLoadValue <= 16'h0002;
    @(posedge clk);
    pauseLoad <= 1'b0;
    for (i = 0; i < 2; i++) begin
      settle(1);
      chk({pauseActive, pauseExpiredFlag}, 32'h2);
      @(posedge clk);
      pauseQuantumTick <= 1'b1;
      @(posedge clk);
      pauseQuantumTick <= 1'b0;
    end
    settle(1);
    chk({pauseActive, pauseExpiredFlag}, 32'h1);
    rdChk(`MAFPS_OFS_STATUS, 32'h0000_2000);
    rdChk(`MAFPS_OFS_STATUS, 32'h0000_0000);
    // Good pause frames at both length limits, read-clear per batch
    wr(`MAFPS_OFS_NETCTL, 32'h0000_0004);
    for (j = 0; j < 2; j++) begin
      wr(`MAFPS_OFS_NETCFG, 32'(j) << 8);
      n = 0;
      for (i = 0; i < 10; i++) begin
        frame(i);
        n += (i != 7 && errs[i] == 3'h0 && lens[i] >= `MAFPS_LEN_MIN
              && lens[i] <= (j ? `MAFPS_LEN_MAX_BIG : `MAFPS_LEN_MAX));
      end
      rdChk(`MAFPS_OFS_PFCNT, 32'(n));
    end
    rdChk(`MAFPS_OFS_PFCNT, 32'h0000_0000);
    // Counter writes need the enable bit; receive enable gates counting
    wr(`MAFPS_OFS_PFCNT, 32'h0000_FFFE);
    rdChk(`MAFPS_OFS_PFCNT, 32'h0000_0000);
    wr(`MAFPS_OFS_NETCTL, 32'h0000_0080);
    frame(1);
    rdChk(`MAFPS_OFS_PFCNT, 32'h0000_0000);
    wr(`MAFPS_OFS_PFCNT, 32'h0000_FFFE);
    wr(`MAFPS_OFS_NETCTL, 32'h0000_0084);
    frame(1);
    frame(1);
    rdChk(`MAFPS_OFS_PFCNT, 32'h0000_FFFF);
    printVerdict();
  end
endmodule

bind mafps_regs mafps_sva #(.SLOTS(SLOTS)) chkU (.clk, .rst_n, .address, .read, .write, .writedata,
  .pauseQuantumTick, .pauseLoad, .rxDestAddr, .rxTypeField, .waitrequest, .slotMatch, .typeMatch,
  .pauseActive, .pauseExpiredFlag, .rmiiSelect, .transceiverClockGate);
